//--- include/pmc_pkg.sv
// Constants and helpers for the performance monitor control block
package pmc_pkg;
   localparam int PMC_DATA_W = 32;
   localparam int PMC_SPRN_W = 10;
   localparam int PMC_TB_W = 64;
   localparam int PMC_NUM_CNT = 4;
   localparam int PMC_THRESH_W = 6;
   localparam int PMC_SEL1_W = 7;
   localparam int PMC_SEL2_W = 6;
   localparam int PMC_PICK_W = 2;

   // Special register numbers
   localparam logic [9:0] PMC_SPRN_PRIMARY = 10'h3B8;
   localparam logic [9:0] PMC_SPRN_MIRROR = 10'h3A8;

   localparam logic [31:0] PMC_RESET_VAL = 32'h0000_0000;

   // Field positions as data bit indices; bit 0 of the manual is data bit 31
   localparam int PMC_B_FREEZE_ALL = 31;
   localparam int PMC_B_FREEZE_SUP = 30;
   localparam int PMC_B_FREEZE_USR = 29;
   localparam int PMC_B_FREEZE_MRK = 28;
   localparam int PMC_B_FREEZE_UNM = 27;
   localparam int PMC_B_IRQ_EN = 26;
   localparam int PMC_B_STOP_IRQ = 25;
   localparam int PMC_F_PICK_LSB = 23;
   localparam int PMC_B_TB_EDGE = 22;
   localparam int PMC_F_THRESH_LSB = 16;
   localparam int PMC_B_FIRST_OVF = 15;
   localparam int PMC_B_UPPER_OVF = 14;
   localparam int PMC_B_HOLD_UPPER = 13;
   localparam int PMC_F_SEL1_LSB = 6;
   localparam int PMC_F_SEL2_LSB = 0;

   // Time base bit picks, manual numbering 63/55/51/47 from the top
   localparam logic [5:0] PMC_TB_IDX_0 = 6'h00;
   localparam logic [5:0] PMC_TB_IDX_1 = 6'h08;
   localparam logic [5:0] PMC_TB_IDX_2 = 6'h0C;
   localparam logic [5:0] PMC_TB_IDX_3 = 6'h10;

   typedef enum logic [1:0] {
      PMC_PICK_B63,
      PMC_PICK_B55,
      PMC_PICK_B51,
      PMC_PICK_B47
   } pmc_pick_t;

   function automatic logic [5:0] pmc_tb_index(input logic [1:0] pick);
      logic [5:0] idx;
      idx = PMC_TB_IDX_0;
      unique case (pmc_pick_t'(pick))
         PMC_PICK_B63: idx = PMC_TB_IDX_0;
         PMC_PICK_B55: idx = PMC_TB_IDX_1;
         PMC_PICK_B51: idx = PMC_TB_IDX_2;
         PMC_PICK_B47: idx = PMC_TB_IDX_3;
      endcase
      return idx;
   endfunction
endpackage

//--- include/pmc_tb_if.sv
// Carrier between control logic and the time base watcher
`timescale 1ns/1ns
interface pmc_tb_if;
   logic [63:0] timebase;
   logic [1:0] pick;
   logic rise;

   modport watch
   (
      input timebase,
      input pick,
      output rise
   );
   modport ctrl
   (
      output timebase,
      output pick,
      input rise
   );
endinterface

//--- rtl/pmc_tb_watch.sv
// Watches one selected time base bit for a zero-to-one transition
`timescale 1ns/1ns
module pmc_tb_watch
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   pmc_tb_if.watch tb
);
   import pmc_pkg::*;

   logic bit_now;
   logic prev_q;
   logic primed_q;
   logic [1:0] pick_q;

   assign bit_now = tb.timebase[pmc_tb_index(tb.pick)];

   ////////////////////////////////////////////////////////////////////
   // Unprimed after reset, and masked by the pick compare in the cycle a new pick arrives, so no false edge is seen
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         prev_q <= 1'b0;
         primed_q <= 1'b0;
         pick_q <= 2'h0;
      end
      else
      begin
         prev_q <= bit_now;
         pick_q <= tb.pick;
         primed_q <= 1'b1;
      end
   end

   assign tb.rise = primed_q && (pick_q == tb.pick) && bit_now && !prev_q;
endmodule

//--- rtl/pmc_ctrl.sv
// Performance monitor primary control register and counting gates
`timescale 1ns/1ns
// What this block does
// - 32-bit supervisor register at special number 952
// - User software may read, never write
// - User mirror read at special number 936
// - Zero after reset; reads change nothing
// - Freeze-all bit stops every counter
// - Freeze counters in supervisor state
// - Freeze counters in user state
// - Freeze counters while process mark set
// - Freeze counters while process mark clear
// - Interrupt enable cleared by hardware on signal
// - Interrupt on enabled overflow or time base edge
// - Counter overflowed when its top bit set
// - Stop-on-interrupt halts the first counter
// - Two-bit field picks watched time base bit
// - Edge enable signals on rise; software-owned
// - Six-bit threshold supports 0 to 63
// - First counter overflow interrupt enable
// - Upper overflow enable overrides stop-on-interrupt for the upper counters only
// - Hold upper counters until trigger event
// - Event selectors for first two counters
module pmc_ctrl
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic spr_wr_i,
   input wire logic spr_rd_i,
   input wire logic [pmc_pkg::PMC_SPRN_W-1:0] spr_num_i,
   input wire logic [pmc_pkg::PMC_DATA_W-1:0] spr_wdata_i,
   input wire logic privilege_state_bit_i,
   input wire logic process_mark_bit_i,
   input wire logic [pmc_pkg::PMC_TB_W-1:0] timebase_i,
   input wire logic [pmc_pkg::PMC_NUM_CNT-1:0] event_counter_top_i,
   output logic spr_ack_o,
   output logic spr_fault_o,
   output logic [pmc_pkg::PMC_DATA_W-1:0] spr_rdata_o,
   output logic [pmc_pkg::PMC_NUM_CNT-1:0] count_enable_o,
   output logic irq_o,
   output logic timebase_rise_o,
   output logic [pmc_pkg::PMC_THRESH_W-1:0] miss_threshold_o,
   output logic [pmc_pkg::PMC_SEL1_W-1:0] first_event_sel_o,
   output logic [pmc_pkg::PMC_SEL2_W-1:0] second_event_sel_o
);
   import pmc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic [PMC_DATA_W-1:0] monitor_control_primary_q;
   logic [PMC_DATA_W-1:0] monitor_control_primary_d;
   logic halted_q;
   logic halted_d;
   logic triggered_q;
   logic triggered_d;
   logic irq_q;
   logic ack_q;
   logic fault_q;
   logic [PMC_DATA_W-1:0] rdata_q;

   logic user_mode;
   logic hit_primary;
   logic hit_mirror;
   logic wr_ok;
   logic rd_ok;
   logic bad_access;

   logic freeze_all;
   logic freeze_in_supervisor;
   logic freeze_in_user;
   logic freeze_when_marked;
   logic freeze_when_unmarked;
   logic irq_signal_enable;
   logic stop_on_irq;
   logic irq_on_timebase_edge;
   logic first_overflow_irq_en;
   logic upper_overflow_irq_en;
   logic hold_upper_until_trigger;

   logic first_overflowed;
   logic upper_overflowed;
   logic irq_cause;
   logic irq_fire;
   logic any_freeze;
   logic first_halt;
   logic upper_halt;
   logic upper_hold;

   pmc_tb_if tb_link();

   ////////////////////////////////////////////////////////////////////
   // Field views of the control register

   assign freeze_all = monitor_control_primary_q[PMC_B_FREEZE_ALL];
   assign freeze_in_supervisor = monitor_control_primary_q[PMC_B_FREEZE_SUP];
   assign freeze_in_user = monitor_control_primary_q[PMC_B_FREEZE_USR];
   assign freeze_when_marked = monitor_control_primary_q[PMC_B_FREEZE_MRK];
   assign freeze_when_unmarked = monitor_control_primary_q[PMC_B_FREEZE_UNM];
   assign irq_signal_enable = monitor_control_primary_q[PMC_B_IRQ_EN];
   assign stop_on_irq = monitor_control_primary_q[PMC_B_STOP_IRQ];
   assign irq_on_timebase_edge = monitor_control_primary_q[PMC_B_TB_EDGE];
   assign first_overflow_irq_en = monitor_control_primary_q[PMC_B_FIRST_OVF];
   assign upper_overflow_irq_en = monitor_control_primary_q[PMC_B_UPPER_OVF];
   assign hold_upper_until_trigger =
      monitor_control_primary_q[PMC_B_HOLD_UPPER];

   assign miss_threshold_o =
      monitor_control_primary_q[PMC_F_THRESH_LSB +: PMC_THRESH_W];
   assign first_event_sel_o =
      monitor_control_primary_q[PMC_F_SEL1_LSB +: PMC_SEL1_W];
   assign second_event_sel_o =
      monitor_control_primary_q[PMC_F_SEL2_LSB +: PMC_SEL2_W];

   ////////////////////////////////////////////////////////////////////
   // Special register access decode

   assign user_mode = privilege_state_bit_i;
   assign hit_primary = (spr_num_i == PMC_SPRN_PRIMARY);
   assign hit_mirror = (spr_num_i == PMC_SPRN_MIRROR);

   assign wr_ok = spr_wr_i && hit_primary && !user_mode;
   assign rd_ok = spr_rd_i && ((hit_primary && !user_mode) || hit_mirror);
   // User touching the primary, or anyone writing the mirror
   assign bad_access = (spr_wr_i && (hit_mirror || (hit_primary && user_mode)))
      || (spr_rd_i && hit_primary && user_mode);

   ////////////////////////////////////////////////////////////////////
   // Time base watcher

   assign tb_link.timebase = timebase_i;
   assign tb_link.pick =
      monitor_control_primary_q[PMC_F_PICK_LSB +: PMC_PICK_W];

   pmc_tb_watch u_tb_watch
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tb(tb_link.watch)
   );

   assign timebase_rise_o = tb_link.rise;

   ////////////////////////////////////////////////////////////////////
   // Interrupt decision

   assign first_overflowed = event_counter_top_i[0];
   assign upper_overflowed = |event_counter_top_i[PMC_NUM_CNT-1:1];

   // first counter overflow gated by its enable
   // any upper counter overflow gated by its enable
   // edge enable allows time base cause
   assign irq_cause = (first_overflow_irq_en && first_overflowed)
      || (upper_overflow_irq_en && upper_overflowed)
      || (irq_on_timebase_edge && tb_link.rise);

   assign irq_fire = irq_signal_enable && irq_cause;

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= irq_fire;
      end
   end

   assign irq_o = irq_q;

   ////////////////////////////////////////////////////////////////////
   // Control register update

   always_comb
   begin
      monitor_control_primary_d = monitor_control_primary_q;
      if (wr_ok)
      begin
         monitor_control_primary_d = spr_wdata_i;
      end
      if (irq_fire)
      begin
         monitor_control_primary_d[PMC_B_IRQ_EN] = 1'b0;
      end
   end

   // zero at reset, reads leave it alone
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         monitor_control_primary_q <= PMC_RESET_VAL;
      end
      else
      begin
         monitor_control_primary_q <= monitor_control_primary_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Halt and trigger state; a new setting of the register restarts both

   always_comb
   begin
      halted_d = halted_q;
      if (wr_ok)
      begin
         halted_d = 1'b0;
      end
      if (irq_fire && stop_on_irq)
      begin
         halted_d = 1'b1;
      end
   end

   always_comb
   begin
      triggered_d = triggered_q;
      if (wr_ok)
      begin
         triggered_d = 1'b0;
      end
      // trigger on first overflow or signal
      if (first_overflowed || irq_fire)
      begin
         triggered_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         halted_q <= 1'b0;
         triggered_q <= 1'b0;
      end
      else
      begin
         halted_q <= halted_d;
         triggered_q <= triggered_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counting gates

   assign any_freeze = freeze_all
      || (freeze_in_supervisor && !privilege_state_bit_i)
      || (freeze_in_user && privilege_state_bit_i)
      || (freeze_when_marked && process_mark_bit_i)
      || (freeze_when_unmarked && !process_mark_bit_i);

   // halt acts in the signalling cycle too
   assign first_halt = stop_on_irq && (halted_q || irq_fire);
   assign upper_halt = first_halt && !upper_overflow_irq_en;
   assign upper_hold = hold_upper_until_trigger && !triggered_q;

   always_comb
   begin
      count_enable_o = '0;
      count_enable_o[0] = !any_freeze && !first_halt;
      for (int i = 1; i < PMC_NUM_CNT; i++)
      begin
         count_enable_o[i] = !any_freeze && !upper_halt && !upper_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read answer, one cycle after the request

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         fault_q <= 1'b0;
         rdata_q <= '0;
      end
      else
      begin
         ack_q <= wr_ok || rd_ok;
         fault_q <= bad_access;
         if (rd_ok)
         begin
            rdata_q <= monitor_control_primary_q;
         end
         else
         begin
            rdata_q <= '0;
         end
      end
   end

   assign spr_ack_o = ack_q;
   assign spr_fault_o = fault_q;
   assign spr_rdata_o = rdata_q;
endmodule

//--- verification/pmc_ctrl_assertions.sv
// Checker for the performance monitor control block ports
`timescale 1ns/1ns
module pmc_ctrl_checker
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic spr_wr_i,
   input wire logic spr_rd_i,
   input wire logic [pmc_pkg::PMC_SPRN_W-1:0] spr_num_i,
   input wire logic [pmc_pkg::PMC_DATA_W-1:0] spr_wdata_i,
   input wire logic privilege_state_bit_i,
   input wire logic process_mark_bit_i,
   input wire logic [pmc_pkg::PMC_TB_W-1:0] timebase_i,
   input wire logic [pmc_pkg::PMC_NUM_CNT-1:0] event_counter_top_i,
   input wire logic spr_ack_o,
   input wire logic spr_fault_o,
   input wire logic [pmc_pkg::PMC_DATA_W-1:0] spr_rdata_o,
   input wire logic [pmc_pkg::PMC_NUM_CNT-1:0] count_enable_o,
   input wire logic irq_o,
   input wire logic timebase_rise_o,
   input wire logic [pmc_pkg::PMC_THRESH_W-1:0] miss_threshold_o,
   input wire logic [pmc_pkg::PMC_SEL1_W-1:0] first_event_sel_o,
   input wire logic [pmc_pkg::PMC_SEL2_W-1:0] second_event_sel_o
);
   import pmc_pkg::*;
   logic [31:0] sh_q;
   logic [5:0] idx;
   logic en;
   logic cause;
   logic [3:0] ce;
   logic p;
   logic m;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   // Shadow copy; stale enable bit during the pulse is masked below
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         sh_q <= '0;
      else
      begin
         if (irq_o)
            sh_q[PMC_B_IRQ_EN] <= 1'b0;
         // A write after the pulse re-arms, so it must win here
         if (spr_wr_i && spr_num_i == PMC_SPRN_PRIMARY && !p)
            sh_q <= spr_wdata_i;
      end
   end
   always_comb
   begin
      case (sh_q[24:23])
         2'h0: idx = 6'h00;
         2'h1: idx = 6'h08;
         2'h2: idx = 6'h0C;
         default: idx = 6'h10;
      endcase
   end
   assign p = privilege_state_bit_i;
   assign m = process_mark_bit_i;
   assign ce = count_enable_o;
   assign en = sh_q[26] && !irq_o;
   assign cause = (event_counter_top_i[0] && sh_q[15])
      || (|event_counter_top_i[3:1] && sh_q[14])
      || (timebase_rise_o && sh_q[22]);
   ////////////////////////////////////////////////////////////////////////
   user_write_refused_a:
      assert property (spr_wr_i && !spr_rd_i && p
         && spr_num_i == PMC_SPRN_PRIMARY |=> spr_fault_o && !spr_ack_o)
      else $error("user write to primary not refused");
   mirror_read_ack_a:
      assert property (spr_rd_i && !spr_wr_i && spr_num_i == PMC_SPRN_MIRROR
         && !irq_o |=> spr_ack_o && spr_rdata_o == $past(sh_q))
      else $error("mirror read wrong");
   freeze_all_a:
      assert property (sh_q[31] |-> ce == 4'h0)
      else $error("counting while frozen");
   freeze_sup_a:
      assert property (sh_q[30] && !p |-> ce == 4'h0)
      else $error("counting in supervisor state");
   freeze_usr_a:
      assert property (sh_q[29] && p |-> ce == 4'h0)
      else $error("counting in user state");
   freeze_mark_a:
      assert property (sh_q[28] && m |-> ce == 4'h0)
      else $error("counting while marked");
   freeze_unmark_a:
      assert property (sh_q[27] && !m |-> ce == 4'h0)
      else $error("counting while unmarked");
   irq_has_cause_a:
      assert property (irq_o |-> $past(en && cause))
      else $error("interrupt without enabled cause");
   cause_gives_irq_a:
      assert property (en && cause |=> irq_o ##1 !irq_o)
      else $error("enabled cause gave no single pulse");
   stop_on_irq_a:
      assert property (irq_o && sh_q[25] && !spr_wr_i |=> !ce[0])
      else $error("first counter runs after interrupt");
   fields_follow_a:
      assert property (miss_threshold_o == sh_q[21:16]
         && first_event_sel_o == sh_q[12:6]
         && second_event_sel_o == sh_q[5:0])
      else $error("field outputs differ from register");
   timebase_rise_a:
      assert property (timebase_rise_o |-> timebase_i[idx]
         && !$past(timebase_i[idx]))
      else $error("rise without picked bit edge");
endmodule
bind pmc_ctrl pmc_ctrl_checker pmc_ctrl_checker_inst
(
   .clk_sys_i(clk_sys_i),
   .rst_i(rst_i),
   .spr_wr_i(spr_wr_i),
   .spr_rd_i(spr_rd_i),
   .spr_num_i(spr_num_i),
   .spr_wdata_i(spr_wdata_i),
   .privilege_state_bit_i(privilege_state_bit_i),
   .process_mark_bit_i(process_mark_bit_i),
   .timebase_i(timebase_i),
   .event_counter_top_i(event_counter_top_i),
   .spr_ack_o(spr_ack_o),
   .spr_fault_o(spr_fault_o),
   .spr_rdata_o(spr_rdata_o),
   .count_enable_o(count_enable_o),
   .irq_o(irq_o),
   .timebase_rise_o(timebase_rise_o),
   .miss_threshold_o(miss_threshold_o),
   .first_event_sel_o(first_event_sel_o),
   .second_event_sel_o(second_event_sel_o)
);

//--- verification/test_perf_monitor_control.sv
// Self-checking bench for the performance monitor control block
`timescale 1ns/1ns
module test_perf_monitor_control;
   import pmc_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, pr = 0, mk = 0;
   logic [9:0] num = '0;
   logic [31:0] wd = '0, mdl = '0, rdat;
   logic [63:0] tb = '0;
   logic [3:0] top = '0, ce;
   logic ack, flt, irq, rise;
   logic [5:0] thr, s2;
   logic [6:0] s1;
   logic [33:0] q[$];
   int n_errors = 0, checks_done = 0, seed = 32222;
   pmc_ctrl pmc_ctrl_inst (.clk_sys_i(clk), .rst_i(rst), .spr_wr_i(wr),
      .spr_rd_i(rd), .spr_num_i(num), .spr_wdata_i(wd),
      .privilege_state_bit_i(pr), .process_mark_bit_i(mk), .timebase_i(tb),
      .event_counter_top_i(top), .spr_ack_o(ack), .spr_fault_o(flt),
      .spr_rdata_o(rdat), .count_enable_o(ce), .irq_o(irq),
      .timebase_rise_o(rise), .miss_threshold_o(thr),
      .first_event_sel_o(s1), .second_event_sel_o(s2));
   initial forever #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [33:0] e, input logic [33:0] s);
      checks_done++;
      if (s !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, s);
         n_errors++;
      end
   endtask
   task results;
      if (n_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // One access; expected answer noted before the response can appear
   task acc(input logic w, r, input logic [9:0] n, input logic [31:0] d,
            input logic u, input logic [1:0] ef);
      if (ef != 2'b00)
         q.push_back({ef, (r && ef[1]) ? mdl : 32'h0000_0000});
      if (w && ef[1])
         mdl = d;
      @(posedge clk);
      wr <= w; rd <= r; num <= n; wd <= d; pr <= u;
      @(posedge clk);
      wr <= 0; rd <= 0;
   endtask
   task wreg(input logic [31:0] d);
      acc(1, 0, PMC_SPRN_PRIMARY, d, 0, 2'b10);
   endtask
   task wait_irq(input logic ex);
      logic seen;
      seen = 0;
      for (int i = 0; i < 10 && !seen; i++)
      begin
         @(negedge clk);
         seen = (irq === 1'b1);
      end
      chk("irq", ex, seen);
      if (seen)
         mdl[26] = 0;
   endtask
   // Response watcher: oldest note against each answer
   always @(negedge clk)
      if (!rst && (ack !== 1'b0 || flt !== 1'b0))
      begin
         if (q.size() == 0)
            chk("spurious", 0, 1);
         else
            chk("response", q.pop_front(), {ack, flt, rdat});
      end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 0;
      acc(0, 1, PMC_SPRN_PRIMARY, 0, 0, 2'b10);
      for (int i = 0; i < 8; i++)
      begin
         wreg($random(seed) & 32'h003F_FFFF | 32'h0020_0000);
         acc(0, 1, PMC_SPRN_MIRROR, 0, 1, 2'b10);
         @(negedge clk);
         chk("fields", {mdl[21:16], mdl[12:0]}, {thr, s1, s2});
      end
      acc(1, 0, PMC_SPRN_PRIMARY, 32'hFFFF_FFFF, 1, 2'b01);
      acc(0, 1, PMC_SPRN_PRIMARY, 0, 1, 2'b01);
      acc(1, 0, PMC_SPRN_MIRROR, 32'hFFFF_FFFF, 0, 2'b01);
      acc(0, 1, 10'h3B9, 0, 0, 2'b00);
      acc(0, 1, PMC_SPRN_PRIMARY, 0, 0, 2'b10);
      for (int b = 0; b < 5; b++)
      begin
         wreg(32'h8000_0000 >> b);
         for (int c = 0; c < 4; c++)
         begin
            @(posedge clk);
            pr <= c[0]; mk <= c[1];
            @(negedge clk);
            chk("enable", ((b == 0) || (b == 1 && !c[0]) || (b == 2 && c[0])
               || (b == 3 && c[1]) || (b == 4 && !c[1])) ? 0 : 4'hF,
               ce);
         end
      end
      wreg(32'h0400_0000);
      top <= 4'h1;
      wait_irq(0);
      wreg(32'h0400_8000);
      wait_irq(1);
      acc(0, 1, PMC_SPRN_PRIMARY, 0, 0, 2'b10);
      top <= 4'h0;
      wreg(32'h0600_4000);
      top <= 4'h4;
      wait_irq(1);
      @(negedge clk);
      chk("stop", 4'hE, ce);
      @(posedge clk);
      top <= 4'h0;
      wreg(32'h0000_2000);
      @(negedge clk);
      chk("hold", 4'h1, ce);
      @(posedge clk);
      top <= 4'h1;
      repeat (2) @(negedge clk);
      chk("trig", 4'hF, ce);
      @(posedge clk);
      top <= 4'h0;
      for (int k = 0; k < 4; k++)
      begin
         tb <= '0;
         wreg(32'h0440_0000 | (k << 23));
         // Edges are masked in the cycle the pick changes
         @(posedge clk);
         tb <= 64'h1 << ((k == 0) ? 0 : 4 + 4 * k);
         wait_irq(1);
         acc(0, 1, PMC_SPRN_PRIMARY, 0, 0, 2'b10);
         wreg(mdl & 32'hFFBF_FFFF);
      end
      repeat (3) @(negedge clk);
      chk("pending", 0, q.size());
      results();
   end
endmodule
